// ===== psc_companion.sv
`timescale 1ns/100ps
// Function
// (RULE1) Reset asserted while supply below programmed trip.
// (RULE2) Reset held 100 ms after supply recovers.
// (RULE3) Watchdog period programmable 100 ms to 3 s.
// (RULE4) Watchdog resets only when software enables it.
// (RULE5) Watchdog expiry asserts reset for 100 ms.
// (RULE6) Flag records low supply or watchdog cause.
// (RULE7) Manual reset on pin filtered and debounced.
// (RULE8) Power-fail sense compared, warning output given.
// (RULE9) Two independent 16-bit backed event counters.
// (RULE10) Counter increments on each qualifying input edge.
// (RULE11) Lockable 64-bit serial number ignores locked writes.
// (RULE12) Reset pin active-low open-drain, also manual input.
// (RULE13) Edge polarity selectable per counter input.
// (RULE14) Watchdog restart reloads full period within tick.
// (RULE15) Reset-source flag held until software clears.
module psc_companion #(
    parameter int TICK_CYCLES = psc_pkg::TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic supply_below_trip,
    input wire logic [psc_pkg::TRIP_W-1:0] trip_sel,
    output logic [psc_pkg::TRIP_W-1:0] trip_sel_out,
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n,
    input wire logic wdg_enable,
    input wire logic [psc_pkg::WDG_SEL_W-1:0] wdg_period_sel,
    input wire logic wdg_restart,
    input wire logic flags_clear,
    output psc_pkg::psc_flags_type reset_flags,
    input wire logic power_fail_sense_in,
    output logic power_fail_warn_out,
    input wire logic event_input_one,
    input wire logic event_input_two,
    input wire logic [psc_pkg::EVC_NUM-1:0] edge_rising_sel,
    input wire logic [psc_pkg::EVC_NUM-1:0] counter_clear,
    output psc_pkg::psc_counts_type event_counts,
    input wire logic [psc_pkg::SERIAL_W-1:0] serial_wr_data,
    input wire logic serial_wr_en,
    input wire logic serial_lock_set,
    output logic [psc_pkg::SERIAL_W-1:0] serial_number,
    output logic serial_locked
);
    import psc_pkg::*;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    logic [TICK_W-1:0] tick_cnt_r;
    logic tick_r;
    psc_state_type state_r;
    logic [MS_W-1:0] hold_cnt_r;
    logic [MS_W-1:0] wdg_cnt_r;
    logic wdg_expire;
    logic [MS_W-1:0] wdg_period;
    logic [WDG_SEL_W-1:0] wdg_sel_clamped;
    logic [MS_W-1:0] deb_cnt_r;
    logic man_armed_r;
    logic man_valid;
    logic driving;
    logic [EVC_NUM-1:0] evc_in;
    logic [EVC_NUM-1:0] evc_prev_r;

    // ==========================================================
    // Millisecond tick divider.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (tick_cnt_r == TICK_LAST) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    // ==========================================================
    // Reset sequencer.
    assign driving = (state_r != PSC_RUN);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= PSC_SUPPLY_LOW;
            hold_cnt_r <= '0;
        end else begin
            unique case (state_r)
                PSC_SUPPLY_LOW: begin
                    if (!supply_below_trip) begin
                        state_r <= PSC_HOLD;
                        hold_cnt_r <= RST_HOLD_TICKS; // RULE2
                    end
                end
                PSC_HOLD: begin
                    if (supply_below_trip) begin
                        state_r <= PSC_SUPPLY_LOW; // RULE1
                    end else if (tick_r) begin
                        if (hold_cnt_r == MS_W'(1)) begin
                            state_r <= PSC_RUN;
                        end
                        hold_cnt_r <= hold_cnt_r - 1'b1;
                    end
                end
                PSC_RUN: begin
                    if (supply_below_trip) begin
                        state_r <= PSC_SUPPLY_LOW; // RULE1
                    end else if (wdg_expire || man_valid) begin
                        state_r <= PSC_HOLD;
                        hold_cnt_r <= RST_HOLD_TICKS; // RULE5
                    end
                end
            endcase
        end
    end

    // Open-drain pin: data is always low, enable low while driving.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= 1'b0;
        end else begin
            rst_pin_out <= 1'b0;
            rst_pin_oe_n <= !driving; // RULE12
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            trip_sel_out <= TRIP_RESET;
        end else begin
            trip_sel_out <= trip_sel; // RULE1
        end
    end

    // ==========================================================
    // Watchdog.
    always_comb begin
        wdg_sel_clamped = wdg_period_sel;
        if (wdg_period_sel < WDG_SEL_MIN) begin
            wdg_sel_clamped = WDG_SEL_MIN; // RULE3
        end else if (wdg_period_sel > WDG_SEL_MAX) begin
            wdg_sel_clamped = WDG_SEL_MAX; // RULE3
        end
    end

    assign wdg_period = MS_W'(wdg_sel_clamped * WDG_STEP_TICKS);
    assign wdg_expire = wdg_enable && !wdg_restart && tick_r // RULE4 RULE14
                        && (wdg_cnt_r == MS_W'(1));

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wdg_cnt_r <= WDG_STEP_TICKS;
        end else if (wdg_restart || !wdg_enable || driving) begin
            wdg_cnt_r <= wdg_period; // RULE14
        end else if (tick_r) begin
            if (wdg_cnt_r == MS_W'(1)) begin
                wdg_cnt_r <= wdg_period;
            end else begin
                wdg_cnt_r <= wdg_cnt_r - 1'b1; // RULE5
            end
        end
    end

    // ==========================================================
    // Reset-source flags; a new cause wins over a clear.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reset_flags <= '0;
        end else begin
            if (state_r != PSC_SUPPLY_LOW && supply_below_trip) begin
                reset_flags.low_supply <= 1'b1; // RULE6
            end else if (flags_clear) begin
                reset_flags.low_supply <= 1'b0; // RULE15
            end
            if (state_r == PSC_RUN && !supply_below_trip && wdg_expire) begin
                reset_flags.watchdog <= 1'b1; // RULE6
            end else if (flags_clear) begin
                reset_flags.watchdog <= 1'b0; // RULE15
            end
        end
    end

    // ==========================================================
    // Manual reset debounce; pin is ignored while this block drives it.
    assign man_valid = man_armed_r && tick_r && (deb_cnt_r == DEBOUNCE_TICKS - 1'b1);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            deb_cnt_r <= '0;
            man_armed_r <= 1'b0;
        end else if (driving || rst_pin_in) begin
            deb_cnt_r <= '0; // RULE7
            man_armed_r <= !driving && rst_pin_in;
        end else if (tick_r && man_armed_r) begin
            if (man_valid) begin
                man_armed_r <= 1'b0; // RULE7
            end
            deb_cnt_r <= deb_cnt_r + 1'b1;
        end
    end

    // ==========================================================
    // Early power-fail warning.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            power_fail_warn_out <= 1'b0;
        end else begin
            power_fail_warn_out <= power_fail_sense_in; // RULE8
        end
    end

    // ==========================================================
    // Event counters.
    assign evc_in = {event_input_two, event_input_one};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            evc_prev_r <= '0;
        end else begin
            evc_prev_r <= evc_in;
        end
    end

    for (genvar i = 0; i < EVC_NUM; i++) begin : g_evc
        logic hit;
        assign hit = edge_rising_sel[i] ? (evc_in[i] && !evc_prev_r[i]) // RULE13
                                        : (!evc_in[i] && evc_prev_r[i]);
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                event_counts[i] <= EVC_RESET; // RULE9
            end else if (hit) begin
                event_counts[i] <= event_counts[i] + 1'b1; // RULE10
            end else if (counter_clear[i]) begin
                event_counts[i] <= EVC_RESET;
            end
        end
    end

    // ==========================================================
    // Serial number with lock.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            serial_number <= SERIAL_RESET;
            serial_locked <= 1'b0;
        end else begin
            if (serial_wr_en && !serial_locked) begin
                serial_number <= serial_wr_data; // RULE11
            end
            if (serial_lock_set) begin
                serial_locked <= 1'b1; // RULE11
            end
        end
    end

endmodule

// ===== psc_companion_chk.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker.
module psc_companion_chk #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic supply_below_trip,
    input wire logic rst_pin_oe_n,
    input wire logic wdg_enable,
    input wire logic wdg_restart,
    input wire logic flags_clear,
    input psc_pkg::psc_flags_type reset_flags,
    input wire logic power_fail_sense_in,
    input wire logic power_fail_warn_out,
    input wire logic event_input_one,
    input wire logic [psc_pkg::EVC_NUM-1:0] edge_rising_sel,
    input wire logic [psc_pkg::EVC_NUM-1:0] counter_clear,
    input psc_pkg::psc_counts_type event_counts,
    input wire logic [psc_pkg::SERIAL_W-1:0] serial_number,
    input wire logic serial_locked
);
    import psc_pkg::*;
    localparam int HOLD_MIN = 99 * TICK_CYCLES;
    logic prev_r;
    logic [31:0] low_r;
    wire logic qual = event_input_one != prev_r && event_input_one == edge_rising_sel[0];
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prev_r <= 1'b0;
            low_r <= 32'h0000_0000;
        end else begin
            prev_r <= event_input_one;
            low_r <= rst_pin_oe_n ? 32'h0000_0000 : low_r + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence wdg_fire_s;
        $rose(reset_flags.watchdog);
    endsequence
    supply_pin_a: assert property (supply_below_trip |=> ##1 !rst_pin_oe_n)
        else $error("Pin not driven on low supply.");
    hold_time_a: assert property ($rose(rst_pin_oe_n) |-> low_r >= HOLD_MIN)
        else $error("Reset released early.");
    flags_sticky_a: assert property
        ((($past(reset_flags) & ~reset_flags) != 2'h0) |-> $past(flags_clear))
        else $error("Flag dropped without clear.");
    wdg_enabled_a: assert property (wdg_fire_s |-> $past(wdg_enable))
        else $error("Disabled watchdog fired.");
    wdg_pin_a: assert property (wdg_fire_s |=> !rst_pin_oe_n)
        else $error("Expiry did not drive pin.");
    restart_safe_a: assert property (wdg_restart |=> !$rose(reset_flags.watchdog))
        else $error("Expiry despite restart.");
    warn_copy_a: assert property (1'b1 |=> power_fail_warn_out == $past(power_fail_sense_in))
        else $error("Warning does not follow sense.");
    count_one_a: assert property (!counter_clear[0] |=>
        event_counts[0] == 16'($past(event_counts[0]) + $past(qual)))
        else $error("Counter one wrong.");
    serial_lock_a: assert property (serial_locked |=> serial_locked && $stable(serial_number))
        else $error("Locked serial changed.");
endmodule

bind psc_companion psc_companion_chk #(.TICK_CYCLES(TICK_CYCLES)) i_psc_companion_chk (
    .sys_clk(sys_clk), .resetn(resetn), .supply_below_trip(supply_below_trip),
    .rst_pin_oe_n(rst_pin_oe_n), .wdg_enable(wdg_enable), .wdg_restart(wdg_restart),
    .flags_clear(flags_clear), .reset_flags(reset_flags),
    .power_fail_sense_in(power_fail_sense_in), .power_fail_warn_out(power_fail_warn_out),
    .event_input_one(event_input_one), .edge_rising_sel(edge_rising_sel),
    .counter_clear(counter_clear), .event_counts(event_counts),
    .serial_number(serial_number), .serial_locked(serial_locked));

// ===== psc_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Host: watchdog service and the reset pin wire.
module psc_host_model (
    input wire logic sys_clk,
    input wire logic kick_on,
    input wire logic press,
    input wire logic rst_pin_oe_n,
    output logic wdg_restart,
    output logic rst_pin_in
);
    logic [7:0] cnt_r = 8'h00;
    initial wdg_restart = 1'b0;
    always @(posedge sys_clk) begin
        wdg_restart <= kick_on && cnt_r == 8'h00;
        cnt_r <= !kick_on ? 8'h00 : cnt_r == 8'h00 ? 8'hc7 : cnt_r - 8'h01;
    end
    assign rst_pin_in = rst_pin_oe_n && !press;
endmodule

// ===== psc_pkg.sv
package psc_pkg;

    // ==========================================================
    // Timing.
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int TICK_W = 16;
    localparam int MS_W = 12;
    localparam int RST_HOLD_MS = 100;
    localparam int WDG_STEP_MS = 100;
    localparam int WDG_MIN_MS = 100;
    localparam int WDG_MAX_MS = 3000;
    localparam int DEBOUNCE_MS = 10;
    localparam logic [MS_W-1:0] RST_HOLD_TICKS = MS_W'(RST_HOLD_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] DEBOUNCE_TICKS = MS_W'(DEBOUNCE_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] WDG_STEP_TICKS = MS_W'(WDG_STEP_MS * 1000 / TICK_US);

    // ==========================================================
    // Watchdog period select, in steps of one hundred milliseconds.
    localparam int WDG_SEL_W = 5;
    localparam logic [WDG_SEL_W-1:0] WDG_SEL_MIN = WDG_SEL_W'(WDG_MIN_MS / WDG_STEP_MS);
    localparam logic [WDG_SEL_W-1:0] WDG_SEL_MAX = WDG_SEL_W'(WDG_MAX_MS / WDG_STEP_MS);

    // ==========================================================
    // Widths and reset values.
    localparam int EVC_NUM = 2;
    localparam int EVC_W = 16;
    localparam int SERIAL_W = 64;
    localparam int TRIP_W = 2;
    localparam logic [EVC_W-1:0] EVC_RESET = 16'h0000;
    localparam logic [SERIAL_W-1:0] SERIAL_RESET = 64'h0000_0000_0000_0000;
    localparam logic [TRIP_W-1:0] TRIP_RESET = 2'h0;

    typedef logic [EVC_NUM-1:0][EVC_W-1:0] psc_counts_type;

    typedef struct packed {
        logic watchdog;
        logic low_supply;
    } psc_flags_type;

    typedef enum logic [1:0] {
        PSC_SUPPLY_LOW,
        PSC_HOLD,
        PSC_RUN
    } psc_state_type;

endpackage

// ===== tb_psc_companion.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_psc_companion;
    import psc_pkg::*;
    localparam int TC = 4;
    logic sys_clk = 1'b0, resetn = 1'b0, supply_below_trip = 1'b0, wdg_enable = 1'b0;
    logic flags_clear = 1'b0, power_fail_sense_in = 1'b0, event_input_one = 1'b0;
    logic event_input_two = 1'b0, serial_wr_en = 1'b0, serial_lock_set = 1'b0;
    logic kick_on = 1'b0, press = 1'b0, p0 = 1'b0, p1 = 1'b0;
    logic wdg_restart, rst_pin_in, rst_pin_oe_n, rst_pin_out, power_fail_warn_out, serial_locked;
    logic [1:0] trip_sel = 2'h0, edge_rising_sel = 2'h3, counter_clear = 2'h0, trip_sel_out;
    logic [4:0] wdg_period_sel = 5'h01;
    logic [4:0] sels [3] = '{5'h00, 5'h02, 5'h1f};
    logic [15:0] c0 = 16'h0000, c1 = 16'h0000;
    logic [63:0] serial_wr_data = 64'h0, serial_number, sn;
    psc_flags_type reset_flags;
    psc_counts_type event_counts;
    int bad_count = 0, checks_done = 0, seed = 82, n, e;
    psc_companion #(.TICK_CYCLES(TC)) i_psc_companion (
        .sys_clk(sys_clk), .resetn(resetn), .supply_below_trip(supply_below_trip),
        .trip_sel(trip_sel), .trip_sel_out(trip_sel_out), .rst_pin_in(rst_pin_in),
        .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .wdg_enable(wdg_enable),
        .wdg_period_sel(wdg_period_sel), .wdg_restart(wdg_restart), .flags_clear(flags_clear),
        .reset_flags(reset_flags), .power_fail_sense_in(power_fail_sense_in),
        .power_fail_warn_out(power_fail_warn_out), .event_input_one(event_input_one),
        .event_input_two(event_input_two), .edge_rising_sel(edge_rising_sel),
        .counter_clear(counter_clear), .event_counts(event_counts),
        .serial_wr_data(serial_wr_data), .serial_wr_en(serial_wr_en),
        .serial_lock_set(serial_lock_set), .serial_number(serial_number),
        .serial_locked(serial_locked));
    psc_host_model i_psc_host_model (.sys_clk(sys_clk), .kick_on(kick_on), .press(press),
        .rst_pin_oe_n(rst_pin_oe_n), .wdg_restart(wdg_restart), .rst_pin_in(rst_pin_in));
    always #12.5 sys_clk = ~sys_clk;
    // ==========================================================
    // Helpers.
    task automatic tick(input int k);
        repeat (k) @(negedge sys_clk);
    endtask
    task automatic wait_pin(input logic v, input int lim);
        n = 0;
        while (rst_pin_oe_n !== v && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic clear_flags;
        flags_clear = 1'b1;
        tick(1);
        flags_clear = 1'b0;
        tick(1);
    endtask
    function automatic int wdg_cycles(input logic [4:0] s);
        return (s == 5'h00 ? 1 : s > 5'h1e ? 30 : int'(s)) * 100 * TC;
    endfunction
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #(40000 * 25);
        bad_count++;
        tally_and_finish;
    end
    // ==========================================================
    // Tests.
    initial begin
        tick(20);
        resetn = 1'b1;
        wait_pin(1'b1, 600);
        `CHK("power-on", 1'b1, n >= 99 * TC)
        supply_below_trip = 1'b1;
        tick(10);
        `CHK("pin", 2'h0, {rst_pin_oe_n, rst_pin_out})
        supply_below_trip = 1'b0;
        wait_pin(1'b1, 800);
        `CHK("hold", 1'b1, n >= 99 * TC && n <= 102 * TC)
        `CHK("flags", 2'h1, reset_flags)
        clear_flags;
        `CHK("cleared", 2'h0, reset_flags)
        $display("Test supply done");
        tick(600);
        wdg_enable = 1'b1;
        `CHK("off", 3'h4, {rst_pin_oe_n, reset_flags})
        kick_on = 1'b1;
        tick(1500);
        kick_on = 1'b0;
        `CHK("kicked", 1'b1, rst_pin_oe_n)
        tick(2);
        foreach (sels[i]) begin
            wdg_period_sel = sels[i];
            wdg_enable = 1'b1;
            kick_on = 1'b1;
            tick(2);
            kick_on = 1'b0;
            e = wdg_cycles(sels[i]);
            wait_pin(1'b0, e + 100);
            `CHK("period", 1'b1, n >= e - 2 * TC && n <= e + 2 * TC)
            `CHK("wdg flag", 2'h2, reset_flags)
            wdg_enable = 1'b0;
            wait_pin(1'b1, 600);
            clear_flags;
        end
        $display("Test watchdog done");
        press = 1'b1;
        tick(5 * TC);
        press = 1'b0;
        tick(4 * TC);
        `CHK("short", 1'b1, rst_pin_oe_n)
        press = 1'b1;
        tick(14 * TC);
        `CHK("long", 1'b0, rst_pin_oe_n)
        press = 1'b0;
        wait_pin(1'b1, 600);
        `CHK("no flag", 2'h0, reset_flags)
        $display("Test manual done");
        for (int k = 0; k < 400; k++) begin
            tick(1);
            {event_input_two, event_input_one} = 2'($random(seed));
            if (k % 50 == 0) edge_rising_sel = 2'($random(seed));
            power_fail_sense_in = 1'($random(seed));
            trip_sel = 2'($random(seed));
            c0 += 16'(event_input_one != p0 && event_input_one == edge_rising_sel[0]);
            c1 += 16'(event_input_two != p1 && event_input_two == edge_rising_sel[1]);
            p0 = event_input_one;
            p1 = event_input_two;
        end
        tick(1);
        `CHK("counts", {c1, c0}, event_counts)
        `CHK("warn", power_fail_sense_in, power_fail_warn_out)
        `CHK("trip", trip_sel, trip_sel_out)
        counter_clear = 2'h3;
        tick(1);
        counter_clear = 2'h0;
        tick(1);
        `CHK("zeroed", 32'h0, event_counts)
        sn = {$random(seed), $random(seed)};
        serial_wr_data = sn;
        serial_wr_en = 1'b1;
        serial_lock_set = 1'b1;
        tick(1);
        serial_lock_set = 1'b0;
        serial_wr_data = ~sn;
        tick(3);
        serial_wr_en = 1'b0;
        `CHK("serial", {1'b1, sn}, {serial_locked, serial_number})
        $display("Test data done");
        tally_and_finish;
    end
endmodule
